// *** logic/gbpc_ctrl.v ***
// Gate brake and pump controller: forced and parking brake sequences,
// passive pull-down control, charge pump level, stage and modulation.
// Assumes an APB master on CLK_SYS and fault inputs synchronous to it.
// Operation
// [RULE1] Supply, interface overvoltage, pump undervoltage or overtemp release gates.
// [RULE2] Drain-source overvoltage after active discharge in Normal releases gates.
// [RULE3] Init, Stop, Fail Safe, Restart, Sleep hold gates off except parking lows.
// [RULE4] Regulator undervoltage, mode 00, pump off, enabled overcurrent pull gates down.
// [RULE5] Forced brake runs only in Normal mode.
// [RULE6] Forced brake first discharges active bridges for their cross conduction time.
// [RULE7] After discharge the forced brake turns the pump off.
// [RULE8] Forced brake routes the PWM input to all low sides; high turns on.
// [RULE9] Forced brake low PWM level turns enabled low sides off.
// [RULE10] Each low side can be excluded from forced brake control.
// [RULE11] Parking brake on Sleep/Stop entry discharges bridges then stops pump; the pump here stops at entry, before discharge.
// [RULE12] Parking brake frees low-side pull-downs, applies high-side pull-downs.
// [RULE13] Parking brake turns low sides on while PWM input is high.
// [RULE14] Level select 0 picks logic-level regulation, reduced high-side drive.
// [RULE15] Level select 1 picks normal-level regulation, equal drive levels.
// [RULE16] Stage auto 0 forces dual stage; 1 enables automatic selection.
// [RULE17] Automatic mode goes single above upper, dual below lower threshold.
// [RULE18] Modulation bit 0 leaves pump clock plain; 1 modulates at 15.6 kHz.
// [RULE19] Each brake step begins only after the previous step has finished.
`include "gbpc_regs.vh"

module gbpc_ctrl #(
   parameter NB       = 3,
   parameter MOD_HALF = `GBPC_FMOD_HALF_CYC
) (
   input  wire          CLK_SYS,
   input  wire          SRST,
   input  wire          PSEL,
   input  wire          PENABLE,
   input  wire          PWRITE,
   input  wire [11:0]   PADDR,
   input  wire [31:0]   PWDATA,
   output reg  [31:0]   PRDATA,
   output wire          PREADY,
   output wire          PSLVERR,
   input  wire [2:0]    DEV_MODE,
   input  wire          VS_OV,
   input  wire          VSINT_OV,
   input  wire          PUMP_UV,
   input  wire          PUMP_OVERTEMP,
   input  wire          VDS_OV,
   input  wire          VCC1_UV,
   input  wire          CSA_OC,
   input  wire          VS_ABOVE_UPPER,
   input  wire          VS_BELOW_LOWER,
   input  wire          PWM_IN_ONE,
   input  wire [NB-1:0] HS_CMD,
   input  wire [NB-1:0] LS_CMD,
   output reg  [NB-1:0] HIGH_GATE_ON,
   output reg  [NB-1:0] LOW_GATE_ON,
   output reg  [NB-1:0] HIGH_GATE_DISCH,
   output reg  [NB-1:0] LOW_GATE_DISCH,
   output reg  [NB-1:0] HIGH_GATE_PULLDOWN,
   output reg  [NB-1:0] LOW_GATE_PULLDOWN,
   output reg           PUMP_ON,
   output reg           PUMP_NORMAL_LEVEL,
   output reg           HS_DRIVE_REDUCED,
   output reg           PUMP_SINGLE_STAGE,
   output reg           PUMP_MOD_CLK,
   output reg           IRQ
);

   localparam S_IDLE = 3'h0;
   localparam S_DISCH = 3'h1;
   localparam S_PUMPOFF = 3'h2;
   localparam S_FBRK = 3'h3;
   localparam S_PBRK = 3'h4;

   reg  [31:0]          ctrl_r;
   reg  [31:0]          bridge_r;
   reg  [31:0]          cct_r;
   reg  [`GBPC_IRQ_W-1:0] irq_stat_r;
   reg  [`GBPC_IRQ_W-1:0] irq_en_r;
   reg  [2:0]           state_r;
   reg  [2:0]           state_nxt;
   reg  [2:0]           mode_prev_r;
   reg                  is_park_r;
   reg  [7:0]           disch_cnt_r [0:NB-1];
   reg  [NB-1:0]        disch_act_r;
   reg                  fault_prev_r;
   reg                  single_nxt;
   reg  [12:0]          mod_cnt_r;
   reg  [NB-1:0]        hon_nxt;
   reg  [NB-1:0]        lon_nxt;
   reg  [NB-1:0]        hpd_nxt;
   reg  [NB-1:0]        lpd_nxt;
   reg  [`GBPC_IRQ_W-1:0] irq_evt;
   reg  [31:0]          rd_data;
   reg                  rd_hit;

   wire wr_en = PSEL & PENABLE & PWRITE;
   wire normal = (DEV_MODE == `GBPC_MODE_NORMAL);
   wire sleep_stop = (DEV_MODE == `GBPC_MODE_STOP) |
                     (DEV_MODE == `GBPC_MODE_SLEEP);
   wire was_sleep_stop = (mode_prev_r == `GBPC_MODE_STOP) |
                         (mode_prev_r == `GBPC_MODE_SLEEP);
   wire forced_req = ctrl_r[`GBPC_FORCED_BRAKE] & normal; // [RULE5]
   wire park_entry = ctrl_r[`GBPC_PARK_EN] & sleep_stop &
                     ~was_sleep_stop; // [RULE11]
   wire [NB-1:0] ls_excl = ctrl_r[`GBPC_LS_EXCL_LSB +: NB];
   wire [NB-1:0] pwm_en = bridge_r[`GBPC_PWM_EN_LSB +: NB];
   wire disch_busy = |disch_act_r;

   // Faults that hand every gate to the pull-downs; drain-source and overcurrent ones only in Normal
   wire fault_pd = VS_OV | VSINT_OV | PUMP_UV | PUMP_OVERTEMP |
                   VCC1_UV | (normal & VDS_OV & ~disch_busy) | // [RULE2]
                   (normal & ctrl_r[`GBPC_OC_EN] & CSA_OC); // [RULE4]

   // Bridge mode decoding, shared by several processes
   function active_mode;
      input [1:0] m;
      begin
         active_mode = (m == `GBPC_HB_LS) | (m == `GBPC_HB_HS);
      end
   endfunction

   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~rd_hit;

   // Address decode for reads and write legality
   always @* begin
      rd_data = 32'h00000000;
      rd_hit = 1'b1;
      if (PADDR == `GBPC_CTRL_OFS) begin
         rd_data = ctrl_r;
      end else if (PADDR == `GBPC_BRIDGE_OFS) begin
         rd_data = bridge_r;
      end else if (PADDR == `GBPC_CCT_OFS) begin
         rd_data = cct_r;
      end else if (PADDR == `GBPC_STATUS_OFS) begin
         rd_data = {24'h000000, PUMP_SINGLE_STAGE, PUMP_ON,
                    fault_pd, disch_busy, 1'b0, state_r};
      end else if (PADDR == `GBPC_IRQ_STAT_OFS) begin
         rd_data = {29'h00000000, irq_stat_r};
      end else if (PADDR == `GBPC_IRQ_CLR_OFS) begin
         rd_data = 32'h00000000;
      end else if (PADDR == `GBPC_IRQ_EN_OFS) begin
         rd_data = {29'h00000000, irq_en_r};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Read data captured in the setup cycle
   always @(posedge CLK_SYS) begin
      if (SRST) begin
         PRDATA <= 32'h00000000;
      end else if (PSEL & ~PENABLE & ~PWRITE) begin
         PRDATA <= rd_data;
      end
   end

   // Writable configuration registers
   always @(posedge CLK_SYS) begin
      if (SRST) begin
         ctrl_r <= `GBPC_CTRL_RST;
         bridge_r <= `GBPC_BRIDGE_RST;
         cct_r <= `GBPC_CCT_RST;
         irq_en_r <= {`GBPC_IRQ_W{1'b0}};
      end else if (wr_en) begin
         if (PADDR == `GBPC_CTRL_OFS) begin
            ctrl_r <= PWDATA & `GBPC_CTRL_MASK;
         end else if (PADDR == `GBPC_BRIDGE_OFS) begin
            bridge_r <= PWDATA & `GBPC_BRIDGE_MASK;
         end else if (PADDR == `GBPC_CCT_OFS) begin
            cct_r <= PWDATA & `GBPC_CCT_MASK;
         end else if (PADDR == `GBPC_IRQ_EN_OFS) begin
            irq_en_r <= PWDATA[`GBPC_IRQ_W-1:0];
         end
      end
   end

   // Sticky events; a new event wins over a clear in the same cycle
   always @(posedge CLK_SYS) begin
      if (SRST) begin
         irq_stat_r <= {`GBPC_IRQ_W{1'b0}};
         IRQ <= 1'b0;
      end else begin
         if (wr_en & (PADDR == `GBPC_IRQ_CLR_OFS)) begin
            irq_stat_r <= (irq_stat_r & ~PWDATA[`GBPC_IRQ_W-1:0]) |
                          irq_evt;
         end else begin
            irq_stat_r <= irq_stat_r | irq_evt;
         end
         IRQ <= |((irq_stat_r | irq_evt) & irq_en_r);
      end
   end

   // Event sources
   always @* begin
      irq_evt = {`GBPC_IRQ_W{1'b0}};
      irq_evt[`GBPC_IRQ_BRAKE] = (state_r == S_IDLE) &
                                 (state_nxt == S_DISCH);
      irq_evt[`GBPC_IRQ_PULLDOWN] = fault_pd & ~fault_prev_r;
      irq_evt[`GBPC_IRQ_STAGE] = single_nxt ^ PUMP_SINGLE_STAGE;
   end

   // Per-bridge active discharge timers
   genvar g;
   generate
      for (g = 0; g < NB; g = g + 1) begin : g_disch
         always @(posedge CLK_SYS) begin
            if (SRST) begin
               disch_cnt_r[g] <= 8'h00;
               disch_act_r[g] <= 1'b0;
            end else if ((state_r == S_IDLE) &
                         (state_nxt == S_DISCH)) begin
               // Only driven bridges need discharging
               disch_act_r[g] <= active_mode(bridge_r[2*g +: 2]) &
                                 (cct_r[8*g +: 8] != 8'h00); // [RULE6]
               disch_cnt_r[g] <= cct_r[8*g +: 8]; // [RULE6]
            end else if (disch_act_r[g]) begin
               if (disch_cnt_r[g] == 8'h01) begin
                  disch_act_r[g] <= 1'b0;
               end
               disch_cnt_r[g] <= disch_cnt_r[g] - 8'h01;
            end
         end
      end
   endgenerate

   // Brake sequencer
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (forced_req | park_entry) begin
               state_nxt = S_DISCH;
            end
         end
         S_DISCH: begin
            if (~forced_req & ~is_park_r) begin
               state_nxt = S_IDLE;
            end else if (~disch_busy) begin
               state_nxt = S_PUMPOFF; // [RULE19]
            end
         end
         S_PUMPOFF: begin
            if (~forced_req & ~is_park_r) begin
               state_nxt = S_IDLE;
            end else if (is_park_r) begin
               state_nxt = S_PBRK; // [RULE19]
            end else begin
               state_nxt = S_FBRK; // [RULE19]
            end
         end
         S_FBRK: begin
            if (~forced_req) begin
               state_nxt = S_IDLE;
            end
         end
         S_PBRK: begin
            if (~sleep_stop) begin
               state_nxt = S_IDLE;
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
      if (is_park_r & ~sleep_stop & (state_r != S_IDLE)) begin
         state_nxt = S_IDLE;
      end
   end

   always @(posedge CLK_SYS) begin
      if (SRST) begin
         state_r <= S_IDLE;
         is_park_r <= 1'b0;
         mode_prev_r <= `GBPC_MODE_INIT;
         fault_prev_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         mode_prev_r <= DEV_MODE;
         fault_prev_r <= fault_pd;
         if ((state_r == S_IDLE) & (state_nxt == S_DISCH)) begin
            is_park_r <= park_entry & ~forced_req;
         end else if (state_nxt == S_IDLE) begin
            is_park_r <= 1'b0;
         end
      end
   end

   // Gate command and pull-down selection
   integer i;
   always @* begin
      hon_nxt = {NB{1'b0}};
      lon_nxt = {NB{1'b0}};
      hpd_nxt = {NB{1'b1}};
      lpd_nxt = {NB{1'b1}};
      for (i = 0; i < NB; i = i + 1) begin
         case (state_r)
            S_IDLE: begin
               // Normal drive only with pump on and bridge enabled
               if (normal & ctrl_r[`GBPC_PUMP_EN] &
                   active_mode(bridge_r[2*i +: 2])) begin // [RULE4]
                  hpd_nxt[i] = 1'b0;
                  lpd_nxt[i] = 1'b0;
                  hon_nxt[i] = HS_CMD[i] & pwm_en[i];
                  lon_nxt[i] = LS_CMD[i] & ~(HS_CMD[i] & pwm_en[i]);
               end
            end
            S_FBRK: begin
               if (~ls_excl[i]) begin // [RULE10]
                  lpd_nxt[i] = 1'b0;
                  lon_nxt[i] = PWM_IN_ONE; // [RULE8] [RULE9]
               end
            end
            S_PBRK: begin
               lpd_nxt[i] = 1'b0; // [RULE12]
               lon_nxt[i] = PWM_IN_ONE; // [RULE13]
            end
            default: begin
               hon_nxt[i] = 1'b0;
            end
         endcase
      end
      // Outside Normal the gates stay pulled down, parking lows aside
      if (~normal & (state_r != S_PBRK)) begin // [RULE3]
         hon_nxt = {NB{1'b0}};
         lon_nxt = {NB{1'b0}};
         hpd_nxt = {NB{1'b1}};
         lpd_nxt = {NB{1'b1}};
      end
      if (fault_pd) begin // [RULE1]
         hon_nxt = {NB{1'b0}};
         lon_nxt = {NB{1'b0}};
         hpd_nxt = {NB{1'b1}};
         lpd_nxt = {NB{1'b1}};
      end
   end

   // Registered gate outputs
   always @(posedge CLK_SYS) begin
      if (SRST) begin
         HIGH_GATE_ON <= {NB{1'b0}};
         LOW_GATE_ON <= {NB{1'b0}};
         HIGH_GATE_DISCH <= {NB{1'b0}};
         LOW_GATE_DISCH <= {NB{1'b0}};
         HIGH_GATE_PULLDOWN <= {NB{1'b1}};
         LOW_GATE_PULLDOWN <= {NB{1'b1}};
      end else begin
         HIGH_GATE_ON <= hon_nxt;
         LOW_GATE_ON <= lon_nxt;
         HIGH_GATE_PULLDOWN <= hpd_nxt;
         LOW_GATE_PULLDOWN <= lpd_nxt;
         // Active discharge while the timer runs
         HIGH_GATE_DISCH <= (state_r == S_DISCH) ?
                            disch_act_r & ~{NB{fault_pd}} :
                            {NB{1'b0}}; // [RULE6] [RULE11]
         LOW_GATE_DISCH <= (state_r == S_DISCH) ?
                           disch_act_r & ~{NB{fault_pd}} :
                           {NB{1'b0}}; // [RULE6] [RULE11]
      end
   end

   // Charge pump enable, level, stage and modulation
   always @* begin
      single_nxt = PUMP_SINGLE_STAGE;
      if (~ctrl_r[`GBPC_STAGE_AUTO]) begin
         single_nxt = 1'b0; // [RULE16]
      end else if (VS_ABOVE_UPPER) begin
         single_nxt = 1'b1; // [RULE17]
      end else if (VS_BELOW_LOWER) begin
         single_nxt = 1'b0; // [RULE17]
      end
   end

   always @(posedge CLK_SYS) begin
      if (SRST) begin
         PUMP_ON <= 1'b0;
         PUMP_NORMAL_LEVEL <= 1'b0;
         HS_DRIVE_REDUCED <= 1'b1;
         PUMP_SINGLE_STAGE <= 1'b0;
         PUMP_MOD_CLK <= 1'b0;
         mod_cnt_r <= 13'h0000;
      end else begin
         // Pump stays off from the pump-off step onward
         PUMP_ON <= ctrl_r[`GBPC_PUMP_EN] & normal &
                    ((state_r == S_IDLE) |
                     (state_r == S_DISCH)); // [RULE7] [RULE11]
         PUMP_NORMAL_LEVEL <= ctrl_r[`GBPC_FET_LEVEL]; // [RULE15]
         HS_DRIVE_REDUCED <= ~ctrl_r[`GBPC_FET_LEVEL]; // [RULE14]
         PUMP_SINGLE_STAGE <= single_nxt;
         if (~ctrl_r[`GBPC_FREQ_MOD]) begin
            mod_cnt_r <= 13'h0000; // [RULE18]
            PUMP_MOD_CLK <= 1'b0;
         end else if (mod_cnt_r == MOD_HALF[12:0] - 13'h0001) begin
            mod_cnt_r <= 13'h0000;
            PUMP_MOD_CLK <= ~PUMP_MOD_CLK; // [RULE18]
         end else begin
            mod_cnt_r <= mod_cnt_r + 13'h0001;
         end
      end
   end

endmodule // gbpc_ctrl

// *** logic/gbpc_regs.vh ***
// Register map, field positions, reset values and timing counts
// for the gate brake and pump controller. Definitions only.
`ifndef GBPC_REGS_VH
`define GBPC_REGS_VH
// Register byte offsets
`define GBPC_CTRL_OFS      12'h000
`define GBPC_BRIDGE_OFS    12'h004
`define GBPC_CCT_OFS       12'h008
`define GBPC_STATUS_OFS    12'h00C
`define GBPC_IRQ_STAT_OFS  12'h010
`define GBPC_IRQ_CLR_OFS   12'h014
`define GBPC_IRQ_EN_OFS    12'h018
// Control register fields
`define GBPC_FORCED_BRAKE  0
`define GBPC_PARK_EN       1
`define GBPC_PUMP_EN       2
`define GBPC_FET_LEVEL     3
`define GBPC_STAGE_AUTO    4
`define GBPC_FREQ_MOD      5
`define GBPC_OC_EN         6
`define GBPC_LS_EXCL_LSB   8
`define GBPC_CTRL_MASK     32'h0000077F
`define GBPC_CTRL_RST      32'h00000020
// Bridge register: mode 2 bits per bridge, pwm enable at 8..10
`define GBPC_PWM_EN_LSB    8
`define GBPC_BRIDGE_MASK   32'h0000073F
`define GBPC_BRIDGE_RST    32'h00000000
// Cross conduction time, 8 bits per bridge, in clock cycles
`define GBPC_CCT_MASK      32'h00FFFFFF
`define GBPC_CCT_RST       32'h00101010
// Half-bridge modes
`define GBPC_HB_OFF        2'b00
`define GBPC_HB_LS         2'b01
`define GBPC_HB_HS         2'b10
// Device modes
`define GBPC_MODE_INIT     3'h0
`define GBPC_MODE_NORMAL   3'h1
`define GBPC_MODE_STOP     3'h2
`define GBPC_MODE_SLEEP    3'h3
`define GBPC_MODE_RESTART  3'h4
`define GBPC_MODE_FAILSAFE 3'h5
// Interrupt bits
`define GBPC_IRQ_BRAKE     0
`define GBPC_IRQ_PULLDOWN  1
`define GBPC_IRQ_STAGE     2
`define GBPC_IRQ_W         3
// Pump modulation timing
`define GBPC_CLK_HZ        100000000
`define GBPC_FMOD_HZ       15600
`define GBPC_FMOD_HALF_CYC (`GBPC_CLK_HZ / `GBPC_FMOD_HZ / 2)
`endif

// *** verif/gate_brake_pump_control_bench.sv ***
// Self-checking bench for the gate brake and pump controller.
// Assumes controller, checker and bridge model are compiled first.
`include "gbpc_regs.vh"
`define CHK(g, e) begin \
   num_checks++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("ERROR t=%0t got %h exp %h", $time, g, e); \
   end \
end
module gate_brake_pump_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat;
   logic        pready, pslverr, vds;
   logic [2:0]  mode = `GBPC_MODE_INIT;
   logic [5:0]  flt = 6'h00;
   logic        above = 1'b0;
   logic        below = 1'b0;
   logic        pwm = 1'b0;
   logic        shrt = 1'b0;
   logic [2:0]  hs_cmd = 3'h0;
   logic [2:0]  ls_cmd = 3'h0;
   logic [2:0]  hg, lg, hd, ld, hp, lp;
   logic        pump, lvl, red, single, modclk, irq;
   logic [2:0]  ml [0:4] = '{`GBPC_MODE_INIT, `GBPC_MODE_STOP,
      `GBPC_MODE_SLEEP, `GBPC_MODE_RESTART, `GBPC_MODE_FAILSAFE};
   int          fails = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          n, shoot;

   always #5 clk = ~clk;

   gbpc_ctrl #(.MOD_HALF(4)) i_dut (
      .CLK_SYS(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .DEV_MODE(mode),
      .VS_OV(flt[0]), .VSINT_OV(flt[1]), .PUMP_UV(flt[2]),
      .PUMP_OVERTEMP(flt[3]), .VDS_OV(vds), .VCC1_UV(flt[4]),
      .CSA_OC(flt[5]), .VS_ABOVE_UPPER(above), .VS_BELOW_LOWER(below),
      .PWM_IN_ONE(pwm), .HS_CMD(hs_cmd), .LS_CMD(ls_cmd),
      .HIGH_GATE_ON(hg), .LOW_GATE_ON(lg), .HIGH_GATE_DISCH(hd),
      .LOW_GATE_DISCH(ld), .HIGH_GATE_PULLDOWN(hp),
      .LOW_GATE_PULLDOWN(lp), .PUMP_ON(pump), .PUMP_NORMAL_LEVEL(lvl),
      .HS_DRIVE_REDUCED(red), .PUMP_SINGLE_STAGE(single),
      .PUMP_MOD_CLK(modclk), .IRQ(irq));

   gbpc_bridge_model i_bridges (.clk(clk), .hi_on(hg), .lo_on(lg),
      .short_req(shrt), .vds_ov(vds), .shoot(shoot));

   // Verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Settle a number of cycles past the edge
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // One APB transfer; unmapped places must answer with an error
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      `CHK(pslverr, a > `GBPC_IRQ_EN_OFS)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Waits for active discharge and measures it in cycles
   task automatic brk(output int len);
      len = 0;
      n = 0;
      while (!(|{hd, ld}) && n < 20) begin
         tick(1);
         n++;
      end
      while (|{hd, ld} && len < 40) begin
         `CHK({hd[2], ld[2]}, 2'b00)
         len++;
         tick(1);
      end
   endtask

   // Counts modulation clock edges over 40 cycles
   task automatic togs(output int t);
      logic p;
      t = 0;
      p = modclk;
      repeat (40) begin
         tick(1);
         if (modclk !== p) t++;
         p = modclk;
      end
   endtask

   // Cuts a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      // Reset values, masks and an unmapped place
      apb(1'b0, `GBPC_CTRL_OFS, 32'h0);
      `CHK(rdat, `GBPC_CTRL_RST)
      apb(1'b0, `GBPC_BRIDGE_OFS, 32'h0);
      `CHK(rdat, `GBPC_BRIDGE_RST)
      apb(1'b1, 12'h01C, 32'hFFFFFFFF);
      apb(1'b0, 12'h01C, 32'h0);
      `CHK(rdat, 32'h00000000)
      apb(1'b0, `GBPC_CTRL_OFS, 32'h0);
      `CHK(rdat, `GBPC_CTRL_RST)
      apb(1'b0, `GBPC_CCT_OFS, 32'h0);
      `CHK(rdat, `GBPC_CCT_RST)
      apb(1'b1, `GBPC_CCT_OFS, 32'hFFFFFFFF);
      apb(1'b0, `GBPC_CCT_OFS, 32'h0);
      `CHK(rdat, `GBPC_CCT_MASK)
      apb(1'b1, `GBPC_CCT_OFS, 32'h00000503);
      $display("test registers done");
      // Level select, stage selection, interrupt, modulation
      mode <= `GBPC_MODE_NORMAL;
      apb(1'b1, `GBPC_CTRL_OFS, 32'h0000002C);
      tick(2);
      `CHK({lvl, red}, 2'b10)
      apb(1'b1, `GBPC_CTRL_OFS, 32'h00000024);
      tick(2);
      `CHK({lvl, red}, 2'b01)
      above <= 1'b1;
      tick(3);
      `CHK(single, 1'b0)
      apb(1'b1, `GBPC_CTRL_OFS, 32'h00000034);
      tick(3);
      `CHK(single, 1'b1)
      above <= 1'b0;
      below <= 1'b1;
      tick(3);
      `CHK(single, 1'b0)
      below <= 1'b0;
      apb(1'b1, `GBPC_IRQ_EN_OFS, 32'h00000004);
      tick(2);
      `CHK(irq, 1'b1)
      apb(1'b1, `GBPC_IRQ_EN_OFS, 32'h00000000);
      tick(2);
      `CHK(irq, 1'b0)
      apb(1'b1, `GBPC_IRQ_EN_OFS, 32'h00000004);
      apb(1'b1, `GBPC_IRQ_CLR_OFS, 32'h00000004);
      tick(2);
      `CHK(irq, 1'b0)
      apb(1'b0, `GBPC_IRQ_STAT_OFS, 32'h0);
      `CHK(rdat[2], 1'b0)
      togs(n);
      `CHK(n, 10)
      apb(1'b1, `GBPC_CTRL_OFS, 32'h00000004);
      tick(2);
      togs(n);
      `CHK(n, 0)
      $display("test pump settings done");
      // Forced brake: ignored outside Normal, then full sequence
      apb(1'b1, `GBPC_BRIDGE_OFS, 32'h00000709);
      apb(1'b1, `GBPC_IRQ_EN_OFS, 32'h00000001);
      mode <= `GBPC_MODE_INIT;
      ls_cmd <= 3'h7;
      apb(1'b1, `GBPC_CTRL_OFS, 32'h00000405);
      tick(4);
      apb(1'b0, `GBPC_STATUS_OFS, 32'h0);
      `CHK(rdat[2:0], 3'h0)
      apb(1'b1, `GBPC_CTRL_OFS, 32'h00000004);
      mode <= `GBPC_MODE_NORMAL;
      tick(4);
      `CHK(pump, 1'b1)
      apb(1'b1, `GBPC_CTRL_OFS, 32'h00000405);
      brk(n);
      `CHK(n, 5)
      tick(2);
      `CHK(pump, 1'b0)
      pwm <= 1'b1;
      tick(3);
      `CHK({hg, lg}, 6'h03)
      `CHK(irq, 1'b1)
      pwm <= 1'b0;
      tick(3);
      `CHK(lg, 3'h0)
      apb(1'b1, `GBPC_CTRL_OFS, 32'h00000004);
      apb(1'b1, `GBPC_IRQ_CLR_OFS, 32'h00000001);
      $display("test forced brake done");
      // Parking brake on entry to Sleep
      ls_cmd <= 3'h0;
      apb(1'b1, `GBPC_CTRL_OFS, 32'h00000006);
      tick(3);
      pwm <= 1'b1;
      mode <= `GBPC_MODE_SLEEP;
      brk(n);
      `CHK(n, 5)
      tick(2);
      `CHK(pump, 1'b0)
      tick(2);
      `CHK({hp, lp}, 6'h38)
      `CHK(lg, 3'h7)
      pwm <= 1'b0;
      tick(3);
      `CHK(lg, 3'h0)
      mode <= `GBPC_MODE_NORMAL;
      $display("test parking brake done");
      // Faults, inactive modes, bridge off and pump off
      apb(1'b1, `GBPC_CTRL_OFS, 32'h00000044);
      hs_cmd <= 3'h1;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         flt <= 6'h01 << i;
         tick(4);
         `CHK({hg, lg, hp, lp}, 12'h03F)
         @(posedge clk);
         flt <= 6'h00;
         tick(3);
      end
      shrt <= 1'b1;
      tick(4);
      `CHK({hg, lg, hp, lp}, 12'h03F)
      shrt <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         mode <= ml[i];
         tick(4);
         `CHK({hg, lg, hp, lp}, 12'h03F)
      end
      mode <= `GBPC_MODE_NORMAL;
      apb(1'b1, `GBPC_BRIDGE_OFS, 32'h00000700);
      tick(3);
      `CHK({hg, lg, hp, lp}, 12'h03F)
      apb(1'b1, `GBPC_BRIDGE_OFS, 32'h00000709);
      apb(1'b1, `GBPC_CTRL_OFS, 32'h00000040);
      tick(3);
      `CHK({hg, lg, hp, lp}, 12'h03F)
      `CHK(shoot, 0)
      $display("test pull-downs done");
      results();
   end
endmodule // gate_brake_pump_control_bench

// *** verif/gbpc_bridge_model.sv ***
// Behavioural model of the three external half-bridges.
// Assumes gate commands from the controller on the bench clock.
module gbpc_bridge_model (
   input  logic       clk,
   input  logic [2:0] hi_on,
   input  logic [2:0] lo_on,
   input  logic       short_req,
   output logic       vds_ov,
   output int         shoot
);
   timeunit 1ns;
   timeprecision 1ps;
   initial shoot = 0;
   // Shorted load shows a drain-source overvoltage; count shoot-through
   always @(posedge clk) begin
      vds_ov <= short_req;
      if (|(hi_on & lo_on)) begin
         shoot <= shoot + 1;
      end
   end
endmodule // gbpc_bridge_model

// *** verif/gbpc_ctrl_assertions.sv ***
// Port checks for the gate brake and pump controller.
// Assumes binding into gbpc_ctrl, one clock with synchronous reset.
`include "gbpc_regs.vh"
module gbpc_chk #(
   parameter NB       = 3,
   parameter MOD_HALF = `GBPC_FMOD_HALF_CYC
) (
   input logic          CLK_SYS,
   input logic          SRST,
   input logic [2:0]    DEV_MODE,
   input logic          VS_OV,
   input logic          VSINT_OV,
   input logic          PUMP_UV,
   input logic          PUMP_OVERTEMP,
   input logic          VCC1_UV,
   input logic          VS_ABOVE_UPPER,
   input logic [NB-1:0] HIGH_GATE_ON,
   input logic [NB-1:0] LOW_GATE_ON,
   input logic [NB-1:0] HIGH_GATE_DISCH,
   input logic [NB-1:0] LOW_GATE_DISCH,
   input logic [NB-1:0] HIGH_GATE_PULLDOWN,
   input logic [NB-1:0] LOW_GATE_PULLDOWN,
   input logic          PUMP_ON,
   input logic          PUMP_NORMAL_LEVEL,
   input logic          HS_DRIVE_REDUCED,
   input logic          PUMP_SINGLE_STAGE,
   input logic          PUMP_MOD_CLK
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        mod_q_r;
   logic        seen_r;
   logic [15:0] gap_r;
   // Summaries of the gate outputs, device mode and modulation clock
   wire disch = |{HIGH_GATE_DISCH, LOW_GATE_DISCH};
   wire off   = !(|{HIGH_GATE_ON, LOW_GATE_ON})
                && (&{HIGH_GATE_PULLDOWN, LOW_GATE_PULLDOWN});
   wire held  = DEV_MODE == `GBPC_MODE_INIT
                || DEV_MODE == `GBPC_MODE_RESTART
                || DEV_MODE == `GBPC_MODE_FAILSAFE;
   wire tog   = PUMP_MOD_CLK != mod_q_r;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   // Cycles since the last modulation clock edge
   always_ff @(posedge CLK_SYS) begin
      mod_q_r <= PUMP_MOD_CLK;
      seen_r  <= !SRST && (seen_r || tog);
      if (SRST || tog) begin
         gap_r <= 16'h0000;
      end else if (gap_r != 16'hFFFF) begin
         gap_r <= gap_r + 16'h0001;
      end
   end
   supply_release_a: assert property (
      (VS_OV || VSINT_OV || PUMP_UV || PUMP_OVERTEMP)[*3] |-> off)
      else $error("gates not released on supply fault");
   mode_hold_a: assert property (held[*3] |-> off)
      else $error("gates not held off in inactive mode");
   regulator_uv_a: assert property (VCC1_UV[*3] |-> off)
      else $error("gates not released on regulator undervoltage");
   brake_order_a: assert property (!(|LOW_GATE_ON && disch))
      else $error("low side on during active discharge");
   pump_stop_a: assert property (
      $fell(disch) |-> ##[0:2] !PUMP_ON)
      else $error("pump still on after discharge");
   level_pair_a: assert property (
      HS_DRIVE_REDUCED == !PUMP_NORMAL_LEVEL)
      else $error("drive level does not follow level select");
   stage_up_a: assert property (
      $rose(PUMP_SINGLE_STAGE) |-> $past(VS_ABOVE_UPPER))
      else $error("single stage without high supply");
   // Rising edges only: turning modulation off may cut a half period
   mod_rate_a: assert property (
      tog && PUMP_MOD_CLK && seen_r |-> gap_r >= MOD_HALF - 1)
      else $error("modulation clock toggles too fast");
endmodule // gbpc_chk

bind gbpc_ctrl gbpc_chk #(.NB(NB), .MOD_HALF(MOD_HALF)) i_chk (
   .CLK_SYS(CLK_SYS), .SRST(SRST), .DEV_MODE(DEV_MODE), .VS_OV(VS_OV),
   .VSINT_OV(VSINT_OV), .PUMP_UV(PUMP_UV), .PUMP_OVERTEMP(PUMP_OVERTEMP),
   .VCC1_UV(VCC1_UV), .VS_ABOVE_UPPER(VS_ABOVE_UPPER),
   .HIGH_GATE_ON(HIGH_GATE_ON), .LOW_GATE_ON(LOW_GATE_ON),
   .HIGH_GATE_DISCH(HIGH_GATE_DISCH), .LOW_GATE_DISCH(LOW_GATE_DISCH),
   .HIGH_GATE_PULLDOWN(HIGH_GATE_PULLDOWN),
   .LOW_GATE_PULLDOWN(LOW_GATE_PULLDOWN), .PUMP_ON(PUMP_ON),
   .PUMP_NORMAL_LEVEL(PUMP_NORMAL_LEVEL),
   .HS_DRIVE_REDUCED(HS_DRIVE_REDUCED),
   .PUMP_SINGLE_STAGE(PUMP_SINGLE_STAGE), .PUMP_MOD_CLK(PUMP_MOD_CLK));
